// >>> verilog/dpm_power_mode_ctrl.sv
// Switch-driven power-mode controller with reconfiguration write sequencer
`timescale 1ns/10ps
`default_nettype none
module dpm_power_mode_ctrl
  import dpm_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DPM_DEBOUNCE_CYC,
  parameter int ADDR_W       = 16,
  parameter int DATA_W       = 32,
  parameter int PORT_W       = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic              pll_sleep_switch_n,
  input  wire logic              gate_switch_n,
  input  wire logic              mode_switch_a_n,
  input  wire logic              mode_switch_b_n,
  output logic                   pll_powerdown_n,
  output logic [3:0]             clock_gate_enable,
  output logic                   fourth_clock_gate_enable,
  output logic [PORT_W-1:0]      output_port_write,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic                   ptarget,
  output logic [ADDR_W-1:0]      paddr,
  output logic [DATA_W-1:0]      pwdata,
  input  wire logic              pready,
  output logic                   serdes_lane_unit_on,
  output logic                   seq_busy,
  output logic                   seq_done
);
  // Narrower buses could not carry the fixed offsets, data words and port codes
  if (ADDR_W < 16 || DATA_W < 32 || PORT_W < 12) begin : g_bad_width
    $error("ADDR_W, DATA_W or PORT_W below the sequence field widths");
  end
  if (DEBOUNCE_CYC < 1) begin : g_bad_debounce
    $error("DEBOUNCE_CYC must be at least 1");
  end

  // ************************************************************
  // Switch conditioning
  // ************************************************************
  logic [3:0] sw_raw;
  logic [3:0] sw_clean;

  assign sw_raw = {mode_switch_b_n, mode_switch_a_n, gate_switch_n, pll_sleep_switch_n};

  for (genvar i = 0; i < 4; i++) begin : g_sw
    dpm_sw_filter #(
      .STABLE_CYC (DEBOUNCE_CYC)
    ) u_filter (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .sw_raw   (sw_raw[i]),
      .sw_clean (sw_clean[i])
    );
  end

  // ************************************************************
  // PLL power-down and clock gating
  // ************************************************************
  logic pll_pd_n_reg;
  logic gate_en_reg;

  // Registered so the PLL pin never sees a glitch from the decode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pll_pd_n_reg <= 1'b1;
    end else if (clk_en) begin
      pll_pd_n_reg <= sw_clean[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate_en_reg <= 1'b1;
    end else if (clk_en) begin
      gate_en_reg <= sw_clean[1];
    end
  end

  // Indicators on clocks zero to two freeze when their clock stops
  assign clock_gate_enable        = {1'b1, {3{gate_en_reg}}};
  assign fourth_clock_gate_enable = 1'b1;
  assign pll_powerdown_n          = pll_pd_n_reg;

  // ************************************************************
  // Mode decode and change detection
  // ************************************************************
  logic [1:0] mode_sel;
  logic       mode_valid;
  logic       mode_on;
  logic       mode_reg;
  logic       mode_known_reg;
  logic       pending_reg;
  logic       pending_on_reg;

  assign mode_sel   = sw_clean[3:2];
  assign mode_valid = (mode_sel == DPM_MODE_OFF) || (mode_sel == DPM_MODE_ON);
  assign mode_on    = (mode_sel == DPM_MODE_ON);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PORT  = 5'b00010,
    ST_SETUP = 5'b00100,
    ST_ACC   = 5'b01000,
    ST_DONE  = 5'b10000
  } dpm_state_t;

  dpm_state_t state_reg;
  dpm_state_t state_next;
  logic [2:0] step_reg;
  logic       start;

  // A change seen during a sequence waits until the sequencer is idle
  assign start = pending_reg && (state_reg == ST_IDLE);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg       <= 1'b1;
      mode_known_reg <= 1'b0;
      pending_reg    <= 1'b0;
      pending_on_reg <= 1'b0;
    end else if (clk_en) begin
      if (mode_valid && (!mode_known_reg || mode_on != mode_reg)) begin
        mode_reg       <= mode_on;
        mode_known_reg <= 1'b1;
        pending_reg    <= 1'b1;
        pending_on_reg <= mode_on;
      end else if (start) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Write sequencer
  // ************************************************************
  // Each step: port value to drive first, then one bus write
  function automatic logic [11:0] step_port(input logic [2:0] s);
    case (s)
      3'h0:    step_port = DPM_PORT_RESET;
      3'h4:    step_port = DPM_PORT_SOFT;
      3'h5:    step_port = DPM_PORT_RESET;
      default: step_port = DPM_PORT_RESET;
    endcase
  endfunction

  function automatic logic [15:0] step_addr(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: step_addr = DPM_TX_RSTPD_OFS;
      3'h2:       step_addr = DPM_RX_RSTPD_OFS;
      3'h3:       step_addr = DPM_RX1_RSTPD_OFS;
      3'h4:       step_addr = DPM_LANE_SOFT_OFS;
      default:    step_addr = DPM_TXPLL_OFS;
    endcase
  endfunction

  function automatic logic [31:0] step_data(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: step_data = DPM_TX_RSTPD_VAL;
      3'h2, 3'h3: step_data = DPM_RX_RSTPD_VAL;
      3'h4:       step_data = DPM_LANE_SOFT_VAL;
      default:    step_data = DPM_TXPLL_VAL;
    endcase
  endfunction

  // Step 1 repeats the transmit write, as the reference sequence does
  logic last_step;
  assign last_step = (step_reg == 3'(DPM_OFF_WRITES - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // On-mode writes are not defined; the change is only recorded
        if (start && !pending_on_reg) begin
          state_next = ST_PORT;
        end
      end
      ST_PORT:  state_next = ST_SETUP;
      ST_SETUP: state_next = ST_ACC;
      ST_ACC: begin
        if (pready) begin
          state_next = last_step ? ST_DONE : ST_PORT;
        end
      end
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_reg <= 3'h0;
    end else if (clk_en) begin
      if (state_reg == ST_IDLE) begin
        step_reg <= 3'h0;
      end else if (state_reg == ST_ACC && pready && !last_step) begin
        step_reg <= step_reg + 3'h1;
      end
    end
  end

  // ************************************************************
  // Port and bus drivers
  // ************************************************************
  logic [PORT_W-1:0] port_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic              tgt_reg;
  logic              on_reg;
  logic              done_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_reg <= PORT_W'(DPM_PORT_IDLE);
    end else if (clk_en && state_reg == ST_PORT) begin
      port_reg <= PORT_W'(step_port(step_reg));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_reg <= '0;
      data_reg <= '0;
      tgt_reg  <= DPM_TGT_LANE;
    end else if (clk_en && state_reg == ST_PORT) begin
      addr_reg <= ADDR_W'(step_addr(step_reg));
      data_reg <= DATA_W'(step_data(step_reg));
      tgt_reg  <= last_step ? DPM_TGT_TXPLL : DPM_TGT_LANE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      on_reg <= 1'b1;
    end else if (clk_en && start) begin
      on_reg <= pending_on_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ST_DONE) begin
        done_reg <= 1'b1;
      end else if (start) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign psel                = (state_reg == ST_SETUP) || (state_reg == ST_ACC);
  assign penable             = (state_reg == ST_ACC);
  assign pwrite              = psel;
  assign ptarget             = tgt_reg;
  assign paddr               = addr_reg;
  assign pwdata              = data_reg;
  assign output_port_write   = port_reg;
  assign serdes_lane_unit_on = on_reg;
  assign seq_busy            = (state_reg != ST_IDLE);
  assign seq_done            = done_reg;
endmodule // dpm_power_mode_ctrl
`default_nettype wire

// >>> verilog/dpm_pkg.sv
// Constants for the demo power-mode controller
package dpm_pkg;
  // Mode switch encodings, as read at the pins (switch ON presents 0)
  localparam logic [1:0] DPM_MODE_OFF       = 2'h1;
  localparam logic [1:0] DPM_MODE_ON        = 2'h2;
  // Output port values driven during the off sequence, and the value loaded at reset
  localparam logic [11:0] DPM_PORT_RESET    = 12'h011;
  localparam logic [11:0] DPM_PORT_SOFT     = 12'h001;
  localparam logic [11:0] DPM_PORT_IDLE     = 12'h000;
  // Register offsets on the reconfiguration port
  localparam logic [15:0] DPM_TX_RSTPD_OFS  = 16'h4078;
  localparam logic [15:0] DPM_RX_RSTPD_OFS  = 16'h404C;
  localparam logic [15:0] DPM_RX1_RSTPD_OFS = 16'h804C;
  localparam logic [15:0] DPM_LANE_SOFT_OFS = 16'h4068;
  localparam logic [15:0] DPM_TXPLL_OFS     = 16'h0008;
  // Write data
  localparam logic [31:0] DPM_TX_RSTPD_VAL  = 32'h00000007;
  localparam logic [31:0] DPM_RX_RSTPD_VAL  = 32'h0000002F;
  localparam logic [31:0] DPM_LANE_SOFT_VAL = 32'h000000D0;
  localparam logic [31:0] DPM_TXPLL_VAL     = 32'h00820010;
  // Bus targets
  localparam logic DPM_TGT_LANE  = 1'b0;
  localparam logic DPM_TGT_TXPLL = 1'b1;
  // Debounce time and its cycle count at 100 MHz
  localparam int DPM_CLK_MHZ        = 100;
  localparam int DPM_DEBOUNCE_US    = 10;
  localparam int DPM_DEBOUNCE_CYC   = DPM_DEBOUNCE_US * DPM_CLK_MHZ;
  // Number of writes in the off sequence
  localparam int DPM_OFF_WRITES     = 6;
endpackage : dpm_pkg

// >>> verilog/dpm_sw_filter.sv
// Synchroniser and debouncer for one switch input
`timescale 1ns/10ps
`default_nettype none
module dpm_sw_filter
  import dpm_pkg::*;
#(
  parameter int STABLE_CYC = DPM_DEBOUNCE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic sw_raw,
  output logic      sw_clean
);
  if (STABLE_CYC < 1) begin : g_bad_stable
    $error("STABLE_CYC must be at least 1");
  end

  localparam int CW = $clog2(STABLE_CYC + 1);

  logic        meta_reg;
  logic        sync_reg;
  logic [CW-1:0] cnt_reg;
  logic        clean_reg;

  // Two-stage synchroniser; the first stage feeds nothing else
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else if (clk_en) begin
      meta_reg <= sw_raw;
      sync_reg <= meta_reg;
    end
  end

  // Output follows only after the level has held steady
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg   <= '0;
      clean_reg <= 1'b1;
    end else if (clk_en) begin
      if (sync_reg == clean_reg) begin
        cnt_reg <= '0;
      end else if (cnt_reg == CW'(STABLE_CYC - 1)) begin
        cnt_reg   <= '0;
        clean_reg <= sync_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign sw_clean = clean_reg;
endmodule // dpm_sw_filter
`default_nettype wire

// >>> verif/dpm_power_mode_ctrl_properties.sv
// Concurrent checks on the power-mode controller ports
`timescale 1ns/10ps
`default_nettype none
module dpm_power_mode_ctrl_properties
  import dpm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        pll_sleep_switch_n,
  input wire logic        gate_switch_n,
  input wire logic        pll_powerdown_n,
  input wire logic [3:0]  clock_gate_enable,
  input wire logic        fourth_clock_gate_enable,
  input wire logic [11:0] output_port_write,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        ptarget,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        seq_busy,
  input wire logic        seq_done
);
  // ****************************************
  // Switch, gate and bus sequence checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  gate_tied_a: assert property (fourth_clock_gate_enable && clock_gate_enable[3])
    else $error("clock three gate enable low");
  // Last pin sample the debouncer must have seen low lies four edges before the fall
  gate_fall_a: assert property ($fell(clock_gate_enable[0]) |->
    !$past(gate_switch_n, 4) && clock_gate_enable[2:0] == 3'h0) else $error("gate fall bad");
  pll_fall_a: assert property ($fell(pll_powerdown_n) |->
    !$past(pll_sleep_switch_n, 4) && !$past(pll_sleep_switch_n, 5)) else $error("pll down bad");
  setup_access_a: assert property (psel && !penable |=> psel && penable)
    else $error("setup not followed by access");
  access_hold_a: assert property (psel && penable && !pready |=>
    psel && penable && $stable(paddr) && $stable(pwdata)) else $error("access not held");
  txrst_write_a: assert property (psel && paddr == DPM_TX_RSTPD_OFS |->
    pwdata == DPM_TX_RSTPD_VAL && output_port_write == DPM_PORT_RESET && !ptarget)
    else $error("tx reset write bad");
  rxrst_write_a: assert property (psel && (paddr == DPM_RX_RSTPD_OFS ||
    paddr == DPM_RX1_RSTPD_OFS) |-> pwdata == DPM_RX_RSTPD_VAL && !ptarget)
    else $error("rx reset write bad");
  soft_reset_a: assert property (psel && paddr == DPM_LANE_SOFT_OFS |->
    pwdata == DPM_LANE_SOFT_VAL && output_port_write == DPM_PORT_SOFT)
    else $error("soft reset write bad");
  txpll_write_a: assert property (psel && ptarget |-> paddr == DPM_TXPLL_OFS &&
    pwdata == DPM_TXPLL_VAL && output_port_write == DPM_PORT_RESET) else $error("pll write bad");
  done_after_a: assert property (psel && penable && pready && ptarget |-> ##[1:3] seq_done)
    else $error("done missing after last write");
  busy_bus_a: assert property (psel |-> seq_busy)
    else $error("bus active while idle");
  cover property (psel && penable && pready && ptarget);
  cover property (psel && penable && !pready);
  cover property ($fell(pll_powerdown_n));
endmodule // dpm_power_mode_ctrl_properties
`default_nettype wire

// >>> verif/dpm_cfg_port_model.sv
// Reconfiguration port target model that logs each completed write
`timescale 1ns/10ps
`default_nettype none
module dpm_cfg_port_model (
  input  wire logic        ref_clk,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        ptarget,
  input  wire logic [11:0] port_val,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready
);
  logic [60:0] log_q[$];
  logic [3:0]  cnt;
  initial pready = 1'b0;
  initial cnt = 4'h0;
  // Ready one cycle wide, after a wait the bench can stretch
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      if (pwrite)
        log_q.push_back({ptarget, port_val, paddr, pwdata});
      pready <= 1'b0;
      cnt    <= 4'h0;
    end else if (psel && penable && cnt >= wait_cyc) begin
      pready <= 1'b1;
    end else begin
      cnt <= (psel && penable) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // dpm_cfg_port_model
`default_nettype wire

// >>> verif/dpm_power_mode_ctrl_tb.sv
// Testbench for the power-mode controller
`timescale 1ns/10ps
`default_nettype none
module dpm_power_mode_ctrl_tb
  import dpm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        pll_n = 1'b1, gate_n = 1'b1, a_n = 1'b1, b_n = 1'b1;
  logic [3:0]  wait_cyc = 4'h0;
  logic        pll_pd_n, fourth_en, psel, penable, pwrite, ptarget, pready, on, busy, seq_done;
  logic [3:0]  gate_en;
  logic [11:0] port;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [60:0] exp_w [6];
  int          err_count = 0;
  int          samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  dpm_power_mode_ctrl #(.DEBOUNCE_CYC(4)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .clk_en(1'b1), .pll_sleep_switch_n(pll_n), .gate_switch_n(gate_n), .mode_switch_a_n(a_n),
    .mode_switch_b_n(b_n), .pll_powerdown_n(pll_pd_n), .clock_gate_enable(gate_en),
    .fourth_clock_gate_enable(fourth_en), .output_port_write(port), .psel(psel),
    .penable(penable), .pwrite(pwrite), .ptarget(ptarget), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .serdes_lane_unit_on(on), .seq_busy(busy), .seq_done(seq_done));
  dpm_cfg_port_model u_model (.ref_clk(ref_clk), .wait_cyc(wait_cyc), .psel(psel),
    .penable(penable), .pwrite(pwrite), .ptarget(ptarget), .port_val(port), .paddr(paddr),
    .pwdata(pwdata), .pready(pready));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Switches are active low: ON presents 0
  task automatic setsw(input logic [3:0] v, input int n);
    @(negedge ref_clk);
    {pll_n, gate_n, a_n, b_n} = v;
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_busy();
    int i;
    for (i = 0; i < 100 && busy !== 1'b1; i++) @(negedge ref_clk);
    chk("seq_busy", 64'h1, {63'h0, busy});
    @(negedge ref_clk);
  endtask
  task automatic wait_done(input int base);
    int i;
    int k;
    for (i = 0; i < 400 && seq_done !== 1'b1; i++) @(negedge ref_clk);
    chk("seq_done", 64'h1, {63'h0, seq_done});
    chk("write count", 64'(base + 6), 64'(u_model.log_q.size()));
    for (k = 0; k < 6 && base + k < u_model.log_q.size(); k++)
      chk("write", {3'h0, exp_w[k]}, {3'h0, u_model.log_q[base + k]});
  endtask
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_w = '{{DPM_TGT_LANE, DPM_PORT_RESET, DPM_TX_RSTPD_OFS, DPM_TX_RSTPD_VAL},
      {DPM_TGT_LANE, DPM_PORT_RESET, DPM_TX_RSTPD_OFS, DPM_TX_RSTPD_VAL},
      {DPM_TGT_LANE, DPM_PORT_RESET, DPM_RX_RSTPD_OFS, DPM_RX_RSTPD_VAL},
      {DPM_TGT_LANE, DPM_PORT_RESET, DPM_RX1_RSTPD_OFS, DPM_RX_RSTPD_VAL},
      {DPM_TGT_LANE, DPM_PORT_SOFT, DPM_LANE_SOFT_OFS, DPM_LANE_SOFT_VAL},
      {DPM_TGT_TXPLL, DPM_PORT_RESET, DPM_TXPLL_OFS, DPM_TXPLL_VAL}};
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    chk("reset outputs", {1'b1, 4'hF, 1'b1, DPM_PORT_IDLE, 4'h0, 1'b1},
      {pll_pd_n, gate_en, fourth_en, port, psel, penable, busy, seq_done, on});
    setsw(4'hB, 14);
    chk("gate off", 5'h11, {gate_en, fourth_en});
    setsw(4'hF, 14);
    chk("gate on", 5'h1F, {gate_en, fourth_en});
    setsw(4'hB, 2);
    setsw(4'hF, 14);
    chk("gate glitch", 4'hF, gate_en);
    setsw(4'h7, 14);
    chk("pll down", 1'b0, pll_pd_n);
    setsw(4'hF, 14);
    chk("pll run", 1'b1, pll_pd_n);
    wait_cyc = 4'h3;
    setsw(4'hE, 0);
    wait_busy();
    chk("mode off", 1'b0, on);
    setsw(4'hD, 0);
    wait_done(0);
    repeat (20) @(negedge ref_clk);
    chk("pending on", {1'b1, 1'b0, 32'd6}, {on, busy, u_model.log_q.size()});
    wait_cyc = 4'h0;
    setsw(4'hE, 0);
    wait_busy();
    wait_done(6);
    setsw(4'hC, 20);
    chk("invalid code", {1'b0, 1'b0, 32'd12}, {on, busy, u_model.log_q.size()});
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule // dpm_power_mode_ctrl_tb
bind dpm_power_mode_ctrl dpm_power_mode_ctrl_properties u_props (.ref_clk, .reset,
  .pll_sleep_switch_n, .gate_switch_n, .pll_powerdown_n, .clock_gate_enable,
  .fourth_clock_gate_enable, .output_port_write, .psel, .penable, .ptarget, .paddr, .pwdata,
  .pready, .seq_busy, .seq_done);
`default_nettype wire
